/* File: pmu_twi_pkg.sv */
// shared constants for the two-wire slave and interrupt controller
package pmu_twi_pkg;
    localparam logic [6:0] addr_default = 7'h49;    // addr_select_pin high
    localparam logic [6:0] addr_alternate = 7'h48;  // addr_select_pin low
    localparam logic [7:0] reg_bus_address_readback = 8'h01;
    localparam logic [7:0] reg_button_seen = 8'h02;
    localparam logic [7:0] reg_button_seen_clear = 8'h03;
    localparam logic [7:0] reg_button_irq_set = 8'h04;
    localparam logic [7:0] reg_irq_enable_set = 8'h08;
    localparam logic [7:0] reg_irq_enable_clear = 8'h09;
    localparam logic [7:0] reg_irq_mask_view = 8'h0a;
    localparam logic [7:0] reg_irq_cause = 8'h0b;
    localparam logic [7:0] irq_mask_reset = 8'h00;
    localparam int bit_global = 7;
    localparam int bit_rtc = 0;
    localparam int bit_button = 1;
    localparam int bit_power = 2;
    localparam int bit_boost = 3;
    localparam int bit_buck = 4;
    localparam int bit_low = 0;
    localparam int bit_high = 1;
    localparam int alt_bit = 7;
    localparam int max_rate_kbps = 400;
endpackage : pmu_twi_pkg

/* File: pmu_twi_slave_irq_control.sv */
// two-wire register slave with interrupt controller and button registers
`timescale 1ns/100ps
module pmu_twi_slave_irq_control (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic wire_clock_in,
    input wire logic wire_data_in,
    output logic wire_data_out, // always low when enabled: open drain
    output logic wire_data_oe_out,
    input wire logic addr_select_pin_in,
    input wire logic iface_select_pin_in,
    input wire logic button_in,
    input wire logic rtc_alarm_in,
    input wire logic power_fail_in,
    input wire logic boost_fail_in,
    input wire logic buck_fail_in,
    output logic irq_ready_pin_out,
    output logic dynamic_twi_out
);
    typedef enum logic [2:0] {st_idle, st_addr, st_reg, st_wdata, st_rdata, st_ack, st_rack} state_t;

    ////////////////////////////////////////////////////////////////////////
    // reset release
    logic rst_s1_r, rst_n_r;
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; first stage feeds only the second
    logic [6:0] s1_r, s2_r;
    logic scl_d_r, sda_d_r;
    always_ff @(posedge clock_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            // idle levels: both bus wires and the button rest high
            s1_r <= 7'h07;
            s2_r <= 7'h07;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            s1_r <= {buck_fail_in, boost_fail_in, power_fail_in, rtc_alarm_in, button_in,
                     wire_data_in, wire_clock_in};
            s2_r <= s1_r;
            scl_d_r <= s2_r[0];
            sda_d_r <= s2_r[1];
        end
    end
    wire scl = s2_r[0];
    wire sda = s2_r[1];
    wire btn = s2_r[2];
    wire scl_rise = scl && !scl_d_r;
    wire scl_fall = !scl && scl_d_r;
    wire start_det = scl && scl_d_r && sda_d_r && !sda;
    wire stop_det = scl && scl_d_r && !sda_d_r && sda;

    ////////////////////////////////////////////////////////////////////////
    // straps caught once after reset release, through their own two flops
    // the capture waits until the synchronised copy holds the pin level
    logic [1:0] strap_s1_r, strap_s2_r;
    logic [1:0] strap_cnt_r;
    logic strap_done_r, alt_r, twi_sel_r;
    always_ff @(posedge clock_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            strap_s1_r <= 2'b11;
            strap_s2_r <= 2'b11;
            strap_cnt_r <= 2'h0;
            strap_done_r <= 1'b0;
            alt_r <= 1'b0;
            twi_sel_r <= 1'b0;
        end else begin
            strap_s1_r <= {iface_select_pin_in, addr_select_pin_in};
            strap_s2_r <= strap_s1_r;
            if (!strap_done_r) begin
                strap_cnt_r <= strap_cnt_r + 2'h1;
                if (strap_cnt_r == 2'h2) begin
                    strap_done_r <= 1'b1;
                    alt_r <= !strap_s2_r[0];
                    twi_sel_r <= !strap_s2_r[1];
                end
            end
        end
    end
    wire [6:0] my_addr = alt_r ? pmu_twi_pkg::addr_alternate : pmu_twi_pkg::addr_default;

    ////////////////////////////////////////////////////////////////////////
    // protocol engine; sda is changed on scl falling edges only
    state_t state_r, ret_r;
    logic [7:0] sh_r, ptr_r, rd_r;
    logic [3:0] cnt_r;
    logic first_r, own_r, pull_r, wr_stb_r, rd_stb_r;
    logic [7:0] wr_data_r;
    logic [7:0] rd_mux;
    wire byte_done = scl_rise && (cnt_r == 4'h7);
    wire [7:0] byte_in = {sh_r[6:0], sda};
    always_ff @(posedge clock_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= st_idle;
            ret_r <= st_idle;
            sh_r <= 8'h00;
            ptr_r <= 8'h00;
            rd_r <= 8'h00;
            cnt_r <= 4'h0;
            first_r <= 1'b0;
            own_r <= 1'b0;
            pull_r <= 1'b0;
            wr_stb_r <= 1'b0;
            rd_stb_r <= 1'b0;
            wr_data_r <= 8'h00;
        end else begin
            wr_stb_r <= 1'b0;
            rd_stb_r <= 1'b0;
            if (!twi_sel_r || stop_det) begin
                state_r <= st_idle;
                pull_r <= 1'b0;
            end else if (start_det) begin
                state_r <= st_addr;
                cnt_r <= 4'h0;
                pull_r <= 1'b0;
            end else begin
                unique case (state_r)
                    st_idle: ;
                    st_addr, st_reg, st_wdata: begin
                        if (scl_rise) begin
                            sh_r <= byte_in;
                            cnt_r <= cnt_r + 4'h1;
                        end
                        if (byte_done) begin
                            own_r <= 1'b1;
                            state_r <= st_ack;
                            if (state_r == st_addr) begin
                                own_r <= (byte_in[7:1] == my_addr);
                                ret_r <= byte_in[0] ? st_rdata : st_reg;
                            end else if (state_r == st_reg) begin
                                ptr_r <= byte_in;
                                ret_r <= st_wdata;
                            end else begin
                                wr_data_r <= byte_in;
                                wr_stb_r <= 1'b1;
                                ret_r <= st_wdata;
                            end
                        end
                    end
                    st_ack: begin
                        if (scl_fall) begin
                            if (!own_r) begin
                                state_r <= st_idle;
                            end else if (pull_r) begin
                                pull_r <= 1'b0;
                                cnt_r <= 4'h0;
                                state_r <= ret_r;
                                if (ret_r == st_rdata) begin
                                    rd_r <= {rd_mux[6:0], 1'b0};
                                    pull_r <= !rd_mux[7];
                                    rd_stb_r <= (ptr_r == pmu_twi_pkg::reg_irq_cause);
                                end
                            end else begin
                                pull_r <= 1'b1;
                            end
                        end
                    end
                    st_rdata: begin
                        if (scl_fall) begin
                            cnt_r <= cnt_r + 4'h1;
                            if (cnt_r == 4'h7) begin
                                pull_r <= 1'b0;
                                state_r <= st_rack;
                            end else begin
                                pull_r <= !rd_r[7];
                                rd_r <= {rd_r[6:0], 1'b0};
                            end
                        end
                    end
                    st_rack: begin
                        if (scl_rise && sda) begin
                            state_r <= st_idle; // master nack ends read
                        end else if (scl_fall) begin
                            // master acked: the next byte leaves on this falling edge
                            cnt_r <= 4'h0;
                            state_r <= st_rdata;
                            rd_r <= {rd_mux[6:0], 1'b0};
                            pull_r <= !rd_mux[7];
                            rd_stb_r <= (ptr_r == pmu_twi_pkg::reg_irq_cause);
                        end
                    end
                    default: begin
                        state_r <= st_idle;
                        pull_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register file
    logic [7:0] mask_r, cause_r;
    logic [1:0] seen_r, btn_en_r;
    logic btn_d_r, irq_r;
    wire wr_en_set = wr_stb_r && ptr_r == pmu_twi_pkg::reg_irq_enable_set;
    wire wr_en_clr = wr_stb_r && ptr_r == pmu_twi_pkg::reg_irq_enable_clear;
    wire wr_seen_clr = wr_stb_r && ptr_r == pmu_twi_pkg::reg_button_seen_clear;
    wire wr_btn_en = wr_stb_r && ptr_r == pmu_twi_pkg::reg_button_irq_set;
    wire btn_evt = (btn != btn_d_r) && ((btn ? btn_en_r[pmu_twi_pkg::bit_high] : btn_en_r[pmu_twi_pkg::bit_low]));
    wire [7:0] src = {3'h0, s2_r[6], s2_r[5], s2_r[4], btn_evt, s2_r[3]};
    wire [7:0] pend = src & mask_r;
    wire [1:0] seen_set = {btn, !btn};
    always_comb begin
        unique case (ptr_r)
            pmu_twi_pkg::reg_bus_address_readback: rd_mux = {alt_r, my_addr};
            pmu_twi_pkg::reg_button_seen: rd_mux = {6'h00, seen_r};
            pmu_twi_pkg::reg_irq_mask_view: rd_mux = mask_r;
            pmu_twi_pkg::reg_irq_cause: rd_mux = cause_r;
            default: rd_mux = 8'h00;
        endcase
    end
    // sticky flags: a new event wins over a clear in the same cycle
    always_ff @(posedge clock_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            mask_r <= pmu_twi_pkg::irq_mask_reset;
            cause_r <= 8'h00;
            seen_r <= 2'b00;
            btn_en_r <= 2'b00;
            btn_d_r <= 1'b1;
            irq_r <= 1'b0;
        end else begin
            btn_d_r <= btn;
            mask_r <= (mask_r | (wr_en_set ? wr_data_r : 8'h00)) & ~(wr_en_clr ? wr_data_r : 8'h00);
            seen_r <= (seen_r & ~(wr_seen_clr ? wr_data_r[1:0] : 2'b00)) | seen_set;
            btn_en_r <= btn_en_r | (wr_btn_en ? wr_data_r[1:0] : 2'b00);
            cause_r <= (rd_stb_r ? 8'h00 : cause_r) | {1'b0, pend[6:0]};
            if (mask_r[pmu_twi_pkg::bit_global] && |pend[6:0]) begin
                irq_r <= 1'b1;
            end else if (rd_stb_r) begin
                irq_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output flops
    always_ff @(posedge clock_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wire_data_out <= 1'b0;
            wire_data_oe_out <= 1'b0;
            irq_ready_pin_out <= 1'b1;
            dynamic_twi_out <= 1'b0;
        end else begin
            wire_data_out <= 1'b0;
            wire_data_oe_out <= pull_r;
            irq_ready_pin_out <= !(irq_r && twi_sel_r);
            dynamic_twi_out <= twi_sel_r;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_mask_reset;
        @(posedge clock_in) $rose(rst_n_r) |-> mask_r == 8'h00;
    endproperty
    a_mask_reset: assert property (p_mask_reset) else $error("mask not zero after reset");
    property p_set;
        @(posedge clock_in) disable iff (!rst_n_r) wr_en_set && !wr_en_clr |=> (mask_r & $past(wr_data_r)) == $past(wr_data_r);
    endproperty
    a_set: assert property (p_set) else $error("enable set lost");
    property p_clr;
        @(posedge clock_in) disable iff (!rst_n_r) wr_en_clr |=> (mask_r & $past(wr_data_r)) == 8'h00;
    endproperty
    a_clr: assert property (p_clr) else $error("enable clear lost");
    property p_od;
        @(posedge clock_in) disable iff (!rst_n_r) wire_data_out == 1'b0;
    endproperty
    a_od: assert property (p_od) else $error("wire_data driven high");
    property p_irq;
        @(posedge clock_in) disable iff (!rst_n_r) twi_sel_r && mask_r[7] && |pend[6:0] |-> ##2 !irq_ready_pin_out;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");
    property p_noglobal;
        @(posedge clock_in) disable iff (!rst_n_r) !mask_r[7] && !irq_r |=> !irq_r;
    endproperty
    a_noglobal: assert property (p_noglobal) else $error("irq without global enable");
    sequence s_cause_read;
        rd_stb_r && !(mask_r[7] && |pend[6:0]);
    endsequence
    property p_release;
        @(posedge clock_in) disable iff (!rst_n_r) s_cause_read |=> !irq_r ##1 irq_ready_pin_out;
    endproperty
    a_release: assert property (p_release) else $error("cause read did not release");
    property p_foreign;
        @(posedge clock_in) disable iff (!rst_n_r) state_r == st_ack && !own_r |-> !pull_r;
    endproperty
    a_foreign: assert property (p_foreign) else $error("acked foreign address");
    property p_seen;
        @(posedge clock_in) disable iff (!rst_n_r) !btn |=> seen_r[0];
    endproperty
    a_seen: assert property (p_seen) else $error("low not seen");
    property p_seen_high;
        @(posedge clock_in) disable iff (!rst_n_r) btn |=> seen_r[1];
    endproperty
    a_seen_high: assert property (p_seen_high) else $error("high not seen");
    // address byte that names this slave leads to an owned acknowledge slot
    sequence s_addr_match;
        state_r == st_addr && byte_done && !start_det && !stop_det && byte_in[7:1] == my_addr;
    endsequence
    property p_addr_ack;
        @(posedge clock_in) disable iff (!rst_n_r) s_addr_match |=> state_r == st_ack && own_r;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("own address not taken");
    sequence s_ack_slot;
        state_r == st_ack && own_r && !pull_r && scl_fall && !start_det && !stop_det;
    endsequence
    property p_ack_pull;
        @(posedge clock_in) disable iff (!rst_n_r) s_ack_slot |=> pull_r ##1 wire_data_oe_out;
    endproperty
    a_ack_pull: assert property (p_ack_pull) else $error("byte not acknowledged");
    property p_idle_quiet;
        @(posedge clock_in) disable iff (!rst_n_r) state_r == st_idle |-> !pull_r;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("wire driven while idle");
    property p_oe_on;
        @(posedge clock_in) disable iff (!rst_n_r) pull_r |=> wire_data_oe_out;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("pull not driven");
    property p_oe_off;
        @(posedge clock_in) disable iff (!rst_n_r) !pull_r |=> !wire_data_oe_out;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("wire not released");
    property p_btn_en;
        @(posedge clock_in) disable iff (!rst_n_r)
            wr_btn_en |=> (btn_en_r & $past(wr_data_r[1:0])) == $past(wr_data_r[1:0]);
    endproperty
    a_btn_en: assert property (p_btn_en) else $error("button enable lost");
    property p_cause_set;
        @(posedge clock_in) disable iff (!rst_n_r)
            |pend[6:0] |=> (cause_r[6:0] & $past(pend[6:0])) == $past(pend[6:0]);
    endproperty
    a_cause_set: assert property (p_cause_set) else $error("cause bit missing");
    property p_ptr;
        @(posedge clock_in) disable iff (!rst_n_r)
            state_r == st_reg && byte_done && twi_sel_r && !start_det && !stop_det |=> ptr_r == $past(byte_in);
    endproperty
    a_ptr: assert property (p_ptr) else $error("register address not taken");
    property p_start;
        @(posedge clock_in) disable iff (!rst_n_r) start_det && twi_sel_r |=> state_r == st_addr;
    endproperty
    a_start: assert property (p_start) else $error("start not seen");
    property p_stop;
        @(posedge clock_in) disable iff (!rst_n_r) stop_det |=> state_r == st_idle && !pull_r;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not seen");
    property p_dyn;
        @(posedge clock_in) disable iff (!rst_n_r) twi_sel_r |=> dynamic_twi_out;
    endproperty
    a_dyn: assert property (p_dyn) else $error("two-wire mode not shown");
    property p_readback;
        @(posedge clock_in) disable iff (!rst_n_r) strap_done_r && ptr_r == pmu_twi_pkg::reg_bus_address_readback
            |-> rd_mux[6:0] == (alt_r ? pmu_twi_pkg::addr_alternate : pmu_twi_pkg::addr_default);
    endproperty
    a_readback: assert property (p_readback) else $error("address readback wrong");
endmodule : pmu_twi_slave_irq_control

/* File: twi_master_model.sv */
// two-wire bus master model that drives the slave port
`timescale 1ns/100ps
module twi_master_model (
    output logic scl_out,
    output logic pull_out,
    input wire logic sda_in
);
    // quarter of the 125 ns bit period used by the bench
    localparam realtime q = 31.25;
    ////////////////////////////////////////////////////////////
    // both lines released at idle; the clock stands still between frames
    initial begin
        scl_out = 1'b1;
        pull_out = 1'b0;
    end
    // data moves only while the clock is low; sampled at the rising edge
    task automatic bit_slot(input logic b, output logic seen);
        #q pull_out = ~b;
        #q scl_out = 1'b1;
        seen = sda_in;
        #(2 * q) scl_out = 1'b0;
    endtask : bit_slot
    // also serves as repeated start from a low clock
    task automatic start();
        #q pull_out = 1'b0;
        #q scl_out = 1'b1;
        #q pull_out = 1'b1;
        #q scl_out = 1'b0;
    endtask : start
    task automatic stop();
        #q pull_out = 1'b1;
        #q scl_out = 1'b1;
        #q pull_out = 1'b0;
        #(2 * q);
    endtask : stop
    // msb first, then the slave's acknowledge slot
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_slot(d[i], s);
        bit_slot(1'b1, s);
        ack = ~s;
    endtask : put_byte
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
        bit_slot(last, s);
    endtask : get_byte
endmodule : twi_master_model

/* File: pmu_twi_slave_irq_control_bench.sv */
// bench: register access, masking and interrupt release over the two-wire port
`timescale 1ns/100ps
module pmu_twi_slave_irq_control_bench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic asel = 1'b1;
    logic btn = 1'b1;
    logic [4:0] src = 5'h00;
    logic scl, pull, oe, dout, irq, dyn;
    logic [6:0] dev = pmu_twi_pkg::addr_default;
    int fail_count = 0;
    int compares = 0;
    // pull-up resolves the open-drain data wire
    wire sda = !((oe && !dout) || pull);
    localparam logic [7:0] seq_d [4] = '{8'h05, 8'h00, 8'h80, 8'h01};
    localparam logic [7:0] seq_m [4] = '{8'h05, 8'h05, 8'h85, 8'h84};
    localparam int srcb [4] = '{pmu_twi_pkg::bit_rtc, pmu_twi_pkg::bit_power,
        pmu_twi_pkg::bit_boost, pmu_twi_pkg::bit_buck};
    always #5 clk = ~clk;
    twi_master_model u_master (.scl_out(scl), .pull_out(pull), .sda_in(sda));
    // iface strap grounded: two-wire mode
    pmu_twi_slave_irq_control DUT (.clock_in(clk), .nrst_in(nrst), .wire_clock_in(scl),
        .wire_data_in(sda), .wire_data_out(dout), .wire_data_oe_out(oe), .addr_select_pin_in(asel),
        .iface_select_pin_in(1'b0), .button_in(btn), .rtc_alarm_in(src[0]), .power_fail_in(src[2]),
        .boost_fail_in(src[3]), .buck_fail_in(src[4]), .irq_ready_pin_out(irq), .dynamic_twi_out(dyn));
    ////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("mismatches %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // straps are sampled just after release, so they are set inside reset
    task automatic do_reset(input logic sel);
        @(posedge clk) #1 nrst = 1'b0;
        asel = sel;
        repeat (5) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (12) @(posedge clk);
    endtask : do_reset
    task automatic head(input logic [7:0] a, output logic [1:0] ak);
        u_master.start();
        u_master.put_byte({dev, 1'b0}, ak[1]);
        u_master.put_byte(a, ak[0]);
    endtask : head
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] ak;
        logic ak2;
        head(a, ak);
        u_master.put_byte(d, ak2);
        u_master.stop();
        chk("write acks", {5'h00, ak, ak2}, 8'h07);
        // shortened command gap; the design holds no slow clock
        #2000;
    endtask : reg_wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [1:0] ak;
        logic ak2;
        logic [7:0] d;
        head(a, ak);
        u_master.start();
        u_master.put_byte({dev, 1'b1}, ak2);
        u_master.get_byte(1'b1, d);
        u_master.stop();
        chk("read acks", {5'h00, ak, ak2}, 8'h07);
        chk($sformatf("reg %h", a), d & m, e);
        #2000;
    endtask : rd_chk
    task automatic foreign(input logic [6:0] a);
        logic [1:0] ak;
        u_master.start();
        u_master.put_byte({a, 1'b0}, ak[1]);
        u_master.put_byte(8'h80, ak[0]);
        u_master.stop();
        chk("foreign acks", {6'h00, ak}, 8'h00);
    endtask : foreign
    // bounded wait on the interrupt pin
    task automatic wait_pin(input logic v);
        int n;
        n = 0;
        while (irq !== v && n < 50) begin
            @(posedge clk);
            n++;
        end
        chk("irq pin", {7'h00, irq}, {7'h00, v});
        if (n == 50) stop_test();
    endtask : wait_pin
    ////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] m;
        do_reset(1'b1);
        chk("dynamic", {7'h00, dyn}, 8'h01);
        chk("irq idle", {7'h00, irq}, 8'h01);
        rd_chk(pmu_twi_pkg::reg_irq_mask_view, 8'hff, 8'h00);
        rd_chk(pmu_twi_pkg::reg_bus_address_readback, 8'hff, 8'h49);
        reg_wr(pmu_twi_pkg::reg_bus_address_readback, 8'h00);
        rd_chk(pmu_twi_pkg::reg_bus_address_readback, 8'hff, 8'h49);
        rd_chk(8'h0f, 8'hff, 8'h00);
        // masking walk: set, set zeros, set global, clear one
        for (int i = 0; i < 4; i++) begin
            reg_wr(i == 3 ? pmu_twi_pkg::reg_irq_enable_clear : pmu_twi_pkg::reg_irq_enable_set, seq_d[i]);
            rd_chk(pmu_twi_pkg::reg_irq_mask_view, 8'hff, seq_m[i]);
        end
        reg_wr(pmu_twi_pkg::reg_irq_enable_clear, 8'h84);
        // each fault source: held off by the global bit, then pending until cause is read
        for (int i = 0; i < 4; i++) begin
            m = 8'h01 << srcb[i];
            reg_wr(pmu_twi_pkg::reg_irq_enable_set, m);
            @(posedge clk) #1 src[srcb[i]] = 1'b1;
            repeat (10) @(posedge clk);
            chk("irq global off", {7'h00, irq}, 8'h01);
            reg_wr(pmu_twi_pkg::reg_irq_enable_set, 8'h80);
            wait_pin(1'b0);
            @(posedge clk) #1 src[srcb[i]] = 1'b0;
            rd_chk(pmu_twi_pkg::reg_irq_cause, m, m);
            wait_pin(1'b1);
            reg_wr(pmu_twi_pkg::reg_irq_enable_clear, 8'h80 | m);
        end
        // button: sticky seen bits, then a low-going interrupt only
        reg_wr(pmu_twi_pkg::reg_button_seen_clear, 8'h03);
        rd_chk(pmu_twi_pkg::reg_button_seen, 8'hff, 8'h02);
        @(posedge clk) #1 btn = 1'b0;
        rd_chk(pmu_twi_pkg::reg_button_seen, 8'hff, 8'h03);
        @(posedge clk) #1 btn = 1'b1;
        reg_wr(pmu_twi_pkg::reg_button_seen_clear, 8'h01);
        reg_wr(pmu_twi_pkg::reg_button_seen_clear, 8'h00);
        rd_chk(pmu_twi_pkg::reg_button_seen, 8'hff, 8'h02);
        reg_wr(pmu_twi_pkg::reg_button_irq_set, 8'h01);
        reg_wr(pmu_twi_pkg::reg_irq_enable_set, 8'h82);
        @(posedge clk) #1 btn = 1'b0;
        wait_pin(1'b0);
        rd_chk(pmu_twi_pkg::reg_irq_cause, 8'h02, 8'h02);
        wait_pin(1'b1);
        @(posedge clk) #1 btn = 1'b1;
        repeat (20) @(posedge clk);
        chk("irq high edge", {7'h00, irq}, 8'h01);
        // second reset with the address strap low
        do_reset(1'b0);
        dev = pmu_twi_pkg::addr_alternate;
        foreign(pmu_twi_pkg::addr_default);
        rd_chk(pmu_twi_pkg::reg_bus_address_readback, 8'hff, 8'hc8);
        rd_chk(pmu_twi_pkg::reg_irq_mask_view, 8'hff, 8'h00);
        stop_test();
    end
endmodule : pmu_twi_slave_irq_control_bench
